/* File: src/usart_flow_consts.vh */
// Register offsets, field positions, reset values and timing for the serial port core
`ifndef USART_FLOW_CONSTS_VH
`define USART_FLOW_CONSTS_VH
`define OFS_LINE_STATUS    8'h00
`define OFS_DATA_WINDOW    8'h04
`define OFS_RATE_DIVIDER   8'h08
`define OFS_CONTROL_ONE    8'h0C
`define OFS_CONTROL_TWO    8'h10
`define OFS_CONTROL_THREE  8'h14
`define RST_LINE_STATUS    32'h0000_00C0
`define RST_DATA_WINDOW    32'h0000_01FF
`define RST_RATE_DIVIDER   32'h0000_0000
`define RST_CONTROL_ONE    32'h0000_0000
`define RST_CONTROL_TWO    32'h0000_0000
`define RST_CONTROL_THREE  32'h0000_6000
// line_status bits
`define SR_PE    0
`define SR_FE    1
`define SR_NF    2
`define SR_ORE   3
`define SR_IDLE  4
`define SR_RX_NOT_EMPTY  5
`define SR_TC    6
`define SR_TXE   7
`define SR_CTS   9
// control_one bits
`define C1_UE       0
`define C1_RE       2
`define C1_TE       3
`define C1_IDLEIE   4
`define C1_RXNEIE   5
`define C1_TCIE     6
`define C1_TXEIE    7
`define C1_PEIE     8
`define C1_SYNC     12
// control_two bits
`define C2_CLKEN    11
`define C2_CPOL     10
// control_three bits
`define C3_ERRIE    0
`define C3_HALF_DUPLEX_SELECT    3
`define C3_DMA_REQUEST_MODE  6
`define C3_REQUEST_CONTROL_ENABLE     8
`define C3_CLEAR_CONTROL_ENABLE     9
`define C3_CTSIE    10
`define C3_CKINE    11
// rate_divider fields
`define BRR_FRAC_LSB 0
`define BRR_FRAC_MSB 3
`define BRR_INT_LSB  4
`define BRR_INT_MSB  15
// Bit clock is pclk over this times the integer divider
`define SYNC_DIV_FACTOR 4
// Bits per frame: start, 8 data, stop
`define FRAME_BITS 10
// Idle length in bit periods
`define IDLE_BITS 10
`endif

/* File: src/usart_flow_dma_core.v */
// Serial port core: divider, half duplex, flow control, interrupts, DMA requests, registers
//
// The strobed register port was chosen for this implementation.
`include "usart_flow_consts.vh"
`default_nettype none
module usart_flow_dma_core #(
  parameter DATA_W = 9
) (
  input  wire        i_clk,
  input  wire        i_arst_n,
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire        i_rx,
  input  wire        i_tx_pin,
  output wire        o_tx,
  output wire        o_tx_oe_n,
  input  wire        i_sclk,
  output wire        o_sclk,
  output wire        o_sclk_oe_n,
  input  wire        i_clear_in_n,
  output wire        o_request_out_n,
  output wire        o_irq,
  output wire        o_dma_tx_req,
  output wire        o_dma_rx_req
);

  // ==========================================================
  // Registers
  reg  [31:0] control_one_ff;
  reg  [31:0] control_two_ff;
  reg  [31:0] control_three_ff;
  reg  [15:0] rate_divider_ff;
  reg  [DATA_W-1:0] tx_hold_ff;
  reg  [DATA_W-1:0] rx_data_ff;
  reg         tx_buffer_empty_ff;
  reg         tx_complete_flag_ff;
  reg         rx_not_empty_ff;
  reg         line_idle_ff;
  reg         overrun_flag_ff;
  reg         noise_flag_ff;
  reg         framing_flag_ff;
  reg         parity_flag_ff;
  reg         clear_change_ff;
  reg         sr_read_ff;

  wire port_enable        = control_one_ff[`C1_UE];
  wire receiver_enable    = control_one_ff[`C1_RE];
  wire transmitter_enable = control_one_ff[`C1_TE];
  wire sync_mode          = control_one_ff[`C1_SYNC];
  wire half_duplex_select = control_three_ff[`C3_HALF_DUPLEX_SELECT];
  wire dma_request_mode   = control_three_ff[`C3_DMA_REQUEST_MODE];
  wire request_control_enable = control_three_ff[`C3_REQUEST_CONTROL_ENABLE];
  wire clear_control_enable   = control_three_ff[`C3_CLEAR_CONTROL_ENABLE];
  wire ext_clock          = control_three_ff[`C3_CKINE];
  wire [11:0] integer_divider = rate_divider_ff[`BRR_INT_MSB:`BRR_INT_LSB];

  // ==========================================================
  // Input synchronisers
  reg [1:0] rx_sync_ff;
  reg [1:0] txp_sync_ff;
  reg [1:0] sclk_sync_ff;
  reg [1:0] cts_sync_ff;
  reg       sclk_prev_ff;
  reg       cts_prev_ff;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_sync_ff   <= 2'h3;
      txp_sync_ff  <= 2'h3;
      sclk_sync_ff <= 2'h0;
      cts_sync_ff  <= 2'h3;
      sclk_prev_ff <= 1'b0;
      cts_prev_ff  <= 1'b1;
    end else begin
      rx_sync_ff   <= {rx_sync_ff[0], i_rx};
      txp_sync_ff  <= {txp_sync_ff[0], i_tx_pin};
      sclk_sync_ff <= {sclk_sync_ff[0], i_sclk};
      cts_sync_ff  <= {cts_sync_ff[0], i_clear_in_n};
      sclk_prev_ff <= sclk_sync_ff[1];
      cts_prev_ff  <= cts_sync_ff[1];
    end
  end

  // Half duplex receives from the transmit pin
  wire rx_line  = half_duplex_select ? txp_sync_ff[1] : rx_sync_ff[1];
  wire cts_edge = cts_sync_ff[1] ^ cts_prev_ff;

  // ==========================================================
  // Bit rate enable
  reg  [15:0] div_cnt_ff;
  wire [15:0] div_total = {2'h0, integer_divider, 2'h0};
  wire        div_tick  = (div_cnt_ff >= div_total - 16'h0001);
  wire        link_active;
  // Internal: one tick per bit period; fractional field unused
  wire        int_tick  = link_active && div_tick;
  // Mid-bit toggle so the output clock gives one full period per bit
  wire        half_tick = link_active && !(sync_mode && ext_clock) &&
                          (div_cnt_ff == {3'h0, integer_divider, 1'b0} - 16'h0001);
  // External clock: one bit per rising edge of sclk
  wire        ext_tick  = sclk_sync_ff[1] & ~sclk_prev_ff;
  wire        bit_tick  = (sync_mode && ext_clock) ? ext_tick : int_tick;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt_ff <= 16'h0000;
    end else if (!link_active || div_tick) begin
      div_cnt_ff <= 16'h0000;
    end else begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
    end
  end

  // ==========================================================
  // Transmitter
  localparam TX_IDLE = 2'b01;
  localparam TX_SEND = 2'b10;
  reg [1:0]        tx_state_ff;
  reg [DATA_W+1:0] tx_shift_ff;
  reg [3:0]        tx_bit_ff;
  reg              tx_out_ff;
  reg              sclk_out_ff;

  wire cts_ok   = !clear_control_enable || !cts_sync_ff[1];
  wire tx_start = (tx_state_ff == TX_IDLE) && port_enable && transmitter_enable &&
                  !tx_buffer_empty_ff && cts_ok;
  // Extra tick keeps the stop bit on the line for a whole bit period
  wire tx_last  = (tx_state_ff == TX_SEND) && bit_tick && (tx_bit_ff == `FRAME_BITS);
  assign link_active = port_enable && (transmitter_enable || receiver_enable);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_shift_ff <= {(DATA_W+2){1'b1}};
      tx_bit_ff   <= 4'h0;
      tx_out_ff   <= 1'b1;
      sclk_out_ff <= 1'b0;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          tx_out_ff   <= 1'b1;
          sclk_out_ff <= control_two_ff[`C2_CPOL];
          if (tx_start) begin
            // Frame fixed here; later clear input changes ignored
            tx_shift_ff <= {1'b1, tx_hold_ff[7:0], 1'b0, 1'b1};
            tx_bit_ff   <= 4'h0;
            tx_state_ff <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (bit_tick || half_tick) begin
            sclk_out_ff <= ~sclk_out_ff;
          end
          if (bit_tick) begin
            tx_out_ff   <= tx_shift_ff[1];
            tx_shift_ff <= {1'b1, tx_shift_ff[DATA_W+1:1]};
            tx_bit_ff   <= tx_bit_ff + 4'h1;
            if (tx_last) begin
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  assign o_tx        = tx_out_ff;
  // Half duplex: drive only while a frame is in flight
  assign o_tx_oe_n   = half_duplex_select ? (tx_state_ff != TX_SEND) : 1'b0;
  assign o_sclk      = sclk_out_ff;
  assign o_sclk_oe_n = !(sync_mode && control_two_ff[`C2_CLKEN] && !ext_clock);

  // ==========================================================
  // Receiver (start, 8 data, stop sampled once per bit)
  localparam RX_IDLE = 2'b01;
  localparam RX_RECV = 2'b10;
  reg [1:0] rx_state_ff;
  reg [8:0] rx_shift_ff;
  reg [3:0] rx_bit_ff;
  reg [3:0] idle_cnt_ff;
  reg       idle_armed_ff;
  wire any_error = overrun_flag_ff | framing_flag_ff | parity_flag_ff;
  wire rx_go     = port_enable && receiver_enable && !framing_flag_ff && !parity_flag_ff;
  wire rx_done   = (rx_state_ff == RX_RECV) && bit_tick && (rx_bit_ff == `FRAME_BITS - 2);
  wire rx_stop_bad = rx_done && !rx_line && !sync_mode;
  wire idle_hit  = !sync_mode && idle_armed_ff && bit_tick && (rx_state_ff == RX_IDLE) &&
                   (idle_cnt_ff == `IDLE_BITS - 1);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_state_ff   <= RX_IDLE;
      rx_shift_ff   <= 9'h000;
      rx_bit_ff     <= 4'h0;
      idle_cnt_ff   <= 4'h0;
      idle_armed_ff <= 1'b0;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          if (rx_go && bit_tick && !rx_line) begin
            rx_state_ff <= RX_RECV;
            rx_bit_ff   <= 4'h0;
            idle_cnt_ff <= 4'h0;
          end else if (bit_tick) begin
            idle_cnt_ff <= idle_hit ? 4'h0 : idle_cnt_ff + 4'h1;
            if (idle_hit) begin
              idle_armed_ff <= 1'b0;
            end
          end
        end
        RX_RECV: begin
          if (bit_tick) begin
            rx_shift_ff <= {rx_line, rx_shift_ff[8:1]};
            rx_bit_ff   <= rx_bit_ff + 4'h1;
            if (rx_done) begin
              rx_state_ff   <= RX_IDLE;
              idle_armed_ff <= 1'b1;
            end
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Register access
  wire wr_sr  = i_wr && (i_addr == `OFS_LINE_STATUS);
  wire wr_dr  = i_wr && (i_addr == `OFS_DATA_WINDOW);
  wire rd_sr  = i_rd && (i_addr == `OFS_LINE_STATUS);
  wire rd_dr  = i_rd && (i_addr == `OFS_DATA_WINDOW);
  wire seq_clear = rd_dr && sr_read_ff;
  wire tx_dw  = wr_dr && transmitter_enable;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_one_ff   <= `RST_CONTROL_ONE;
      control_two_ff   <= `RST_CONTROL_TWO;
      control_three_ff <= `RST_CONTROL_THREE;
      rate_divider_ff  <= 16'h0000;
      tx_hold_ff       <= {DATA_W{1'b1}};
      sr_read_ff       <= 1'b0;
    end else begin
      if (i_wr && i_addr == `OFS_CONTROL_ONE)   control_one_ff   <= i_wdata & 32'h0000_11FD;
      if (i_wr && i_addr == `OFS_CONTROL_TWO)   control_two_ff   <= i_wdata & 32'h0000_0C00;
      if (i_wr && i_addr == `OFS_CONTROL_THREE) control_three_ff <= i_wdata & 32'h0000_6F49;
      if (i_wr && i_addr == `OFS_RATE_DIVIDER)  rate_divider_ff  <= i_wdata[15:0];
      if (tx_dw) tx_hold_ff <= i_wdata[DATA_W-1:0];
      if (rd_sr) sr_read_ff <= 1'b1;
      else if (i_rd) sr_read_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Status flags (hardware set wins over clear, except TXE and TC, where a data write wins over the load and the end-of-frame set)
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_buffer_empty_ff  <= 1'b1;
      tx_complete_flag_ff <= 1'b1;
      rx_not_empty_ff     <= 1'b0;
      line_idle_ff        <= 1'b0;
      overrun_flag_ff     <= 1'b0;
      noise_flag_ff       <= 1'b0;
      framing_flag_ff     <= 1'b0;
      parity_flag_ff      <= 1'b0;
      clear_change_ff     <= 1'b0;
      rx_data_ff          <= {DATA_W{1'b1}};
    end else begin
      // A write in the load cycle refills the buffer at once
      if (tx_dw) tx_buffer_empty_ff <= 1'b0;
      else if (tx_start) tx_buffer_empty_ff <= 1'b1;
      if (!transmitter_enable || (tx_last && tx_buffer_empty_ff && !tx_dw))
        tx_complete_flag_ff <= 1'b1;
      else if (tx_dw)
        tx_complete_flag_ff <= 1'b0;
      if (rx_done && !rx_not_empty_ff) begin
        rx_data_ff      <= {{(DATA_W-8){1'b0}}, rx_shift_ff[8:1]};
        rx_not_empty_ff <= 1'b1;
      end else if (rd_dr || (wr_sr && !i_wdata[`SR_RX_NOT_EMPTY])) begin
        rx_not_empty_ff <= 1'b0;
      end
      if (rx_done && rx_not_empty_ff) overrun_flag_ff <= 1'b1;
      else if (seq_clear) overrun_flag_ff <= 1'b0;
      if (rx_stop_bad) framing_flag_ff <= 1'b1;
      else if (seq_clear) framing_flag_ff <= 1'b0;
      if (idle_hit) line_idle_ff <= 1'b1;
      else if (seq_clear) line_idle_ff <= 1'b0;
      if (seq_clear) begin
        noise_flag_ff  <= 1'b0;
        parity_flag_ff <= 1'b0;
      end
      if (clear_control_enable && cts_edge) clear_change_ff <= 1'b1;
      else if (wr_sr && !i_wdata[`SR_CTS]) clear_change_ff <= 1'b0;
    end
  end

  wire [31:0] status_word = {22'h00_0000, clear_change_ff, 1'b0, tx_buffer_empty_ff,
                             tx_complete_flag_ff, rx_not_empty_ff, line_idle_ff,
                             overrun_flag_ff, noise_flag_ff, framing_flag_ff, parity_flag_ff};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `OFS_LINE_STATUS:   o_rdata <= status_word;
        `OFS_DATA_WINDOW:   o_rdata <= {{(32-DATA_W){1'b0}}, rx_data_ff};
        `OFS_RATE_DIVIDER:  o_rdata <= {16'h0000, rate_divider_ff};
        `OFS_CONTROL_ONE:   o_rdata <= control_one_ff;
        `OFS_CONTROL_TWO:   o_rdata <= control_two_ff;
        `OFS_CONTROL_THREE: o_rdata <= control_three_ff;
        default:            o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Flow control, interrupt and DMA outputs
  assign o_request_out_n = request_control_enable ? (rx_not_empty_ff | any_error) : 1'b1;

  wire async_ok = !sync_mode;
  wire errs     = overrun_flag_ff | (async_ok & (noise_flag_ff | framing_flag_ff));
  assign o_irq = (control_one_ff[`C1_TXEIE]   & tx_buffer_empty_ff) |
                 (control_three_ff[`C3_CTSIE] & clear_change_ff) |
                 (control_one_ff[`C1_TCIE]    & tx_complete_flag_ff) |
                 (control_one_ff[`C1_RXNEIE]  & rx_not_empty_ff) |
                 (control_one_ff[`C1_IDLEIE]  & line_idle_ff & async_ok) |
                 (control_one_ff[`C1_PEIE]    & parity_flag_ff & async_ok) |
                 (control_three_ff[`C3_ERRIE] & errs);

  assign o_dma_tx_req = dma_request_mode && port_enable && transmitter_enable && tx_buffer_empty_ff;
  assign o_dma_rx_req = dma_request_mode && port_enable && receiver_enable && rx_not_empty_ff;

endmodule
`default_nettype wire

/* File: testbench/usart_flow_dma_core_sva.sv */
// Port checker for the serial port core
`include "usart_flow_consts.vh"
`default_nettype none
module usart_flow_dma_core_chk (
  input wire        i_clk,
  input wire        i_arst_n,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        o_tx_oe_n,
  input wire        o_sclk_oe_n,
  input wire        o_request_out_n,
  input wire        o_irq,
  input wire        o_dma_tx_req,
  input wire        o_dma_rx_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] c1_ff;
  logic [31:0] c2_ff;
  logic [31:0] c3_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================
  // Shadow copies of the control registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      c1_ff <= 32'h0000_0000;
      c2_ff <= 32'h0000_0000;
      c3_ff <= 32'h0000_6000;
    end else if (i_wr) begin
      if (i_addr == `OFS_CONTROL_ONE) c1_ff <= i_wdata;
      if (i_addr == `OFS_CONTROL_TWO) c2_ff <= i_wdata;
      if (i_addr == `OFS_CONTROL_THREE) c3_ff <= i_wdata;
    end
  end
  // ==========================================
  // Properties
  property p_rts_off; !c3_ff[`C3_REQUEST_CONTROL_ENABLE] |-> o_request_out_n; endproperty
  a_rts_off: assert property (p_rts_off) else $error("request low without control");
  property p_rts_busy; c3_ff[`C3_REQUEST_CONTROL_ENABLE] && o_dma_rx_req |-> o_request_out_n; endproperty
  a_rts_busy: assert property (p_rts_busy) else $error("request low while data waits");
  property p_dma_off; !c3_ff[`C3_DMA_REQUEST_MODE] |-> !o_dma_tx_req && !o_dma_rx_req; endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma request outside dma mode");
  property p_dma_tx; o_dma_tx_req |-> c1_ff[`C1_UE] && c1_ff[`C1_TE]; endproperty
  a_dma_tx: assert property (p_dma_tx) else $error("tx dma request while disabled");
  property p_dma_rx; o_dma_rx_req |-> c1_ff[`C1_UE] && c1_ff[`C1_RE]; endproperty
  a_dma_rx: assert property (p_dma_rx) else $error("rx dma request while disabled");
  property p_irq_off;
    c1_ff[`C1_PEIE:`C1_IDLEIE] == 5'h0 && !c3_ff[`C3_ERRIE] && !c3_ff[`C3_CTSIE] |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");
  property p_oe_full; !c3_ff[`C3_HALF_DUPLEX_SELECT] |-> !o_tx_oe_n; endproperty
  a_oe_full: assert property (p_oe_full) else $error("tx released outside half duplex");
  property p_sr_rsvd;
    $past(i_rd) && $past(i_addr) == `OFS_LINE_STATUS |-> o_rdata[31:10] == 22'h0 && !o_rdata[8];
  endproperty
  a_sr_rsvd: assert property (p_sr_rsvd) else $error("status reserved bits set");
  property p_sclk; !o_sclk_oe_n |-> c1_ff[`C1_SYNC] && c2_ff[`C2_CLKEN]; endproperty
  a_sclk: assert property (p_sclk) else $error("clock pin driven outside sync mode");
endmodule
`default_nettype wire

/* File: testbench/serial_peer.sv */
// Far-end serial transmitter model
`default_nettype none
module serial_peer #(
  parameter int BIT = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_bad_stop,
  output var  logic       o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] fr;
  int         n;
  initial begin
    o_line = 1'b1;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        fr = {~i_bad_stop, i_byte, 1'b0};
        for (n = 0; n < 10; n++) begin
          o_line <= fr[n];
          repeat (BIT) @(posedge i_clk);
        end
        o_line <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/usart_flow_dma_core_tb.sv */
// Self-checking bench for the serial port core
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module usart_flow_dma_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_clear_in_n = 1'b1;
  logic        peer_go = 1'b0;
  logic [7:0]  peer_byte = 8'h00;
  logic        peer_bad = 1'b0;
  logic [31:0] o_rdata;
  logic        o_tx, o_tx_oe_n, o_sclk, o_sclk_oe_n, o_request_out_n, o_irq, o_dma_tx_req, o_dma_rx_req, rx_line;
  wire  logic  tx_pin = o_tx_oe_n ? 1'b1 : o_tx;
  int          err_total = 0, samples_checked = 0, cyc = 0, i, k, t0 = 0, t1 = 0;
  logic [31:0] rd;
  logic [9:0]  fr;
  logic        hi;
  typedef struct { logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; } row_t;
  row_t rows[10] = '{'{8'h00, 1'b0, 32'h0000_0000, 32'h0000_00c0}, '{8'h04, 1'b0, 32'h0000_0000, 32'h0000_01ff},
    '{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0000}, '{8'h0c, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{8'h10, 1'b0, 32'h0000_0000, 32'h0000_0000}, '{8'h14, 1'b0, 32'h0000_0000, 32'h0000_6000},
    '{8'h18, 1'b1, 32'hffff_ffff, 32'h0000_0000}, '{8'h18, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{8'h08, 1'b1, 32'hffff_0020, 32'h0000_0000}, '{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0020}};
  usart_flow_dma_core usart_flow_dma_core_inst (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx(rx_line), .i_tx_pin(tx_pin), .o_tx, .o_tx_oe_n, .i_sclk(1'b0), .o_sclk, .o_sclk_oe_n, .i_clear_in_n,
    .o_request_out_n, .o_irq, .o_dma_tx_req, .o_dma_rx_req);
  serial_peer #(.BIT(8)) serial_peer_inst (.i_clk, .i_go(peer_go), .i_byte(peer_byte), .i_bad_stop(peer_bad),
    .o_line(rx_line));
  always #10 i_clk = ~i_clk;
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= r;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1 rd = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask
  task automatic rdr(input logic [7:0] a);
    bus(a, 32'h0000_0000, 1'b0, 1'b1);
  endtask
  task automatic send(input logic [7:0] b, input logic bad);
    peer_byte <= b;
    peer_bad <= bad;
    peer_go <= 1'b1;
    @(posedge i_clk);
    peer_go <= 1'b0;
  endtask
  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    `CHK({o_tx, o_request_out_n, o_irq, o_dma_tx_req, o_dma_rx_req}, 5'b11000)
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    foreach (rows[j]) begin
      bus(rows[j].a, rows[j].d, rows[j].w, !rows[j].w);
      if (!rows[j].w) `CHK(rd, rows[j].e)
    end
    // ==========================================
    // Asynchronous frame, dma and complete flag
    wr(8'h14, 32'h0000_6040);
    wr(8'h0c, 32'h0000_0049);
    `CHK(o_dma_tx_req, 1'b1)
    wr(8'h04, 32'h0000_005a);
    for (i = 0; i < 400 && o_tx !== 1'b0; i++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
    for (i = 0; i < 10; i++) begin
      fr[i] = o_tx;
      repeat (8) @(posedge i_clk);
    end
    `CHK(fr, {1'b1, 8'h5a, 1'b0})
    repeat (4) @(posedge i_clk);
    rdr(8'h00);
    `CHK({rd[7:6], o_irq}, 3'b111)
    wr(8'h04, 32'h0000_0033);
    rdr(8'h00);
    `CHK({rd[6], o_irq}, 2'b00)
    repeat (100) @(posedge i_clk);
    // ==========================================
    // Half duplex line release
    wr(8'h14, 32'h0000_6008);
    `CHK(o_tx_oe_n, 1'b1)
    wr(8'h04, 32'h0000_000f);
    for (i = 0; i < 50 && o_tx_oe_n !== 1'b0; i++) @(posedge i_clk);
    repeat (40) @(posedge i_clk);
    `CHK(o_tx_oe_n, 1'b0)
    repeat (60) @(posedge i_clk);
    `CHK(o_tx_oe_n, 1'b1)
    // ==========================================
    // Clear-to-send flag and gating
    wr(8'h0c, 32'h0000_0009);
    wr(8'h14, 32'h0000_0600);
    i_clear_in_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rdr(8'h00);
    `CHK({rd[9:8], o_irq}, 3'b101)
    wr(8'h00, 32'h0000_0000);
    rdr(8'h00);
    `CHK({rd[9], o_irq}, 2'b00)
    i_clear_in_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    wr(8'h04, 32'h0000_0011);
    hi = 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge i_clk);
      hi &= o_tx;
    end
    `CHK(hi, 1'b1)
    i_clear_in_n <= 1'b0;
    for (i = 0; i < 40 && o_tx !== 1'b0; i++) @(posedge i_clk);
    `CHK(o_tx, 1'b0)
    repeat (100) @(posedge i_clk);
    // ==========================================
    // Receive with request and dma, then a framing error
    wr(8'h14, 32'h0000_6140);
    wr(8'h0c, 32'h0000_0005);
    `CHK({o_request_out_n, o_dma_rx_req}, 2'b00)
    send(8'h3c, 1'b0);
    for (i = 0; i < 200 && o_dma_rx_req !== 1'b1; i++) @(posedge i_clk);
    `CHK({o_request_out_n, o_dma_rx_req}, 2'b11)
    rdr(8'h00);
    `CHK(rd[5], 1'b1)
    rdr(8'h04);
    `CHK(rd[7:0], 8'h3c)
    `CHK({o_request_out_n, o_dma_rx_req}, 2'b00)
    send(8'h81, 1'b1);
    for (i = 0; i < 200 && o_request_out_n !== 1'b1; i++) @(posedge i_clk);
    rdr(8'h00);
    `CHK({rd[1], o_request_out_n}, 2'b11)
    rdr(8'h04);
    rdr(8'h00);
    `CHK({rd[1], o_request_out_n}, 2'b00)
    // ==========================================
    // Synchronous clock rate with divider two
    wr(8'h10, 32'h0000_0800);
    wr(8'h0c, 32'h0000_1009);
    wr(8'h04, 32'h0000_00a5);
    `CHK(o_sclk_oe_n, 1'b0)
    k = 0;
    hi = o_sclk;
    for (i = 0; i < 400 && k < 3; i++) begin
      @(posedge i_clk);
      if (o_sclk && !hi) begin
        k++;
        t0 = t1;
        t1 = i;
      end
      hi = o_sclk;
    end
    `CHK(t1 - t0, 8)
    end_of_test();
  end
endmodule
bind usart_flow_dma_core usart_flow_dma_core_chk usart_flow_dma_core_chk_inst (.i_clk, .i_arst_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_tx_oe_n, .o_sclk_oe_n, .o_request_out_n, .o_irq, .o_dma_tx_req, .o_dma_rx_req);
`default_nettype wire
